// ==== design/dcrm_register_bank.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Control word two: divider, multiplier at 0x01.
// - Bits 7,6 pick CMOS or crystal clock.
// - Bit 5 set powers the PLL down.
// - Bit 3 set halves the PLL reference.
// - Bit 1 clear holds PLL logic reset.
// - Bit 0 reads back PLL lock status.
// - DAC register 0x02, 10-bit full-scale current.
// - Frequency step word, 32 bits at 0x03.
// - Phase shift word, 14 bits at 0x04.
// - Sweep registers effective only when enabled.
// - Sweep limits at 0x06: upper, lower.
// - Sweep steps 0x07 high: decrement step.
// - Sweep steps low: increment step.
// - Ramp rate 0x08 high: falling interval.
// - Ramp rate low: rising interval.
// - Eight profiles, chosen by select pins.
// - Profiles 0x09..0x10, 14-bit phase field.
// - Profile low word is tuning value.
// - Apply strobe commits writes; buffers keep them.
module dcrm_register_bank #(
  parameter int PROFILE_COUNT = dcrm_pkg::PROFILES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wrValid,
  input wire logic [dcrm_pkg::ADDR_W-1:0] wrAddr,
  input wire logic [dcrm_pkg::DATA_W-1:0] wrData,
  input wire logic rdValid,
  input wire logic [dcrm_pkg::ADDR_W-1:0] rdAddr,
  output logic [dcrm_pkg::DATA_W-1:0] rdData,
  output logic rdDone,
  input wire logic applyPin,
  input wire logic [dcrm_pkg::PSEL_W-1:0] profileSelectPin,
  input wire logic pllLockIn,
  input wire logic auxAccumEnable,
  input wire logic modulusEnable,
  output logic applyPulse,
  output logic pllDivOut,
  output logic [dcrm_pkg::PLL_MULT_W-1:0] pllMult,
  output logic cmosClockMode,
  output logic crystalClockMode,
  output logic pllPowerDown,
  output logic lowReferenceRange,
  output logic pllRefHalf,
  output logic oscillatorBandSelect,
  output logic pllLogicReset,
  output logic [dcrm_pkg::FSC_W-1:0] fullScaleCurrent,
  output logic [dcrm_pkg::WORD_W-1:0] frequencyStepWord,
  output logic [dcrm_pkg::PHASE_W-1:0] phaseShiftWord,
  output logic sweepEffective,
  output dcrm_pkg::dcrm_pair_t sweepLimits,
  output dcrm_pkg::dcrm_pair_t sweepSteps,
  output logic [dcrm_pkg::RATE_W-1:0] fallRampRate,
  output logic [dcrm_pkg::RATE_W-1:0] riseRampRate,
  output logic [dcrm_pkg::WORD_W-1:0] profileFreq,
  output logic [dcrm_pkg::PHASE_W-1:0] profilePhase
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The first stage is never looked at; apply also looks at a third.
  logic applyMeta;
  logic applySync;
  logic applyLast;
  logic [dcrm_pkg::PSEL_W-1:0] selMeta;
  logic [dcrm_pkg::PSEL_W-1:0] selSync;
  logic lockMeta;
  logic lockSync;
  logic applyEdge;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      applyMeta <= 1'b0;
      applySync <= 1'b0;
      applyLast <= 1'b0;
    end else begin
      applyMeta <= applyPin;
      applySync <= applyMeta;
      applyLast <= applySync;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      selMeta <= '0;
      selSync <= '0;
    end else begin
      selMeta <= profileSelectPin;
      selSync <= selMeta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lockMeta <= 1'b0;
      lockSync <= 1'b0;
    end else begin
      lockMeta <= pllLockIn;
      lockSync <= lockMeta;
    end
  end

  // A level held high on the strobe pin commits only once.
  assign applyEdge = applySync & ~applyLast;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer registers, written by the host side.
  logic [15:0] bufPll;
  logic [31:0] bufDac;
  logic [31:0] bufFreq;
  logic [15:0] bufPhase;
  logic [63:0] bufLimits;
  logic [63:0] bufSteps;
  logic [31:0] bufRate;
  dcrm_pkg::dcrm_profile_t bufProfile [PROFILE_COUNT];
  logic [4:0] profileOffset;

  assign profileOffset = wrAddr - dcrm_pkg::ADDR_PROFILE_FIRST;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bufPll <= dcrm_pkg::RST_PLL_CTRL;
      bufDac <= dcrm_pkg::RST_DAC_CTRL;
      bufFreq <= dcrm_pkg::RST_WORD;
      bufPhase <= dcrm_pkg::RST_PHASE;
      bufLimits <= dcrm_pkg::RST_WIDE;
      bufSteps <= dcrm_pkg::RST_WIDE;
      bufRate <= dcrm_pkg::RST_WORD;
    end else if (wrValid) begin
      case (wrAddr)
        dcrm_pkg::ADDR_PLL_CTRL: begin
          // The lock bit is not storable; it always reflects the PLL.
          bufPll <= {wrData[15:1], 1'b0};
        end
        dcrm_pkg::ADDR_DAC_CTRL: begin
          bufDac <= wrData[31:0];
        end
        dcrm_pkg::ADDR_FREQ_STEP: begin
          bufFreq <= wrData[31:0];
        end
        dcrm_pkg::ADDR_PHASE_SHIFT: begin
          bufPhase <= wrData[15:0];
        end
        dcrm_pkg::ADDR_SWEEP_LIMITS: begin
          bufLimits <= wrData;
        end
        dcrm_pkg::ADDR_SWEEP_STEPS: begin
          bufSteps <= wrData;
        end
        dcrm_pkg::ADDR_SWEEP_RATE: begin
          bufRate <= wrData[31:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < PROFILE_COUNT; i++) begin
      if (rst) begin
        bufProfile[i] <= dcrm_pkg::RST_PROFILE;
      end else if (wrValid && wrAddr >= dcrm_pkg::ADDR_PROFILE_FIRST &&
                   wrAddr <= dcrm_pkg::ADDR_PROFILE_LAST &&
                   profileOffset == 5'(i)) begin
        bufProfile[i] <= wrData[47:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active copies, loaded only on the apply strobe.
  dcrm_pkg::dcrm_pll_t actPll;
  logic [31:0] actDac;
  logic [31:0] actFreq;
  logic [15:0] actPhase;
  logic [63:0] actLimits;
  logic [63:0] actSteps;
  logic [31:0] actRate;
  dcrm_pkg::dcrm_profile_t actProfile [PROFILE_COUNT];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      actPll <= dcrm_pkg::RST_PLL_CTRL;
      actDac <= dcrm_pkg::RST_DAC_CTRL;
      actFreq <= dcrm_pkg::RST_WORD;
      actPhase <= dcrm_pkg::RST_PHASE;
      actLimits <= dcrm_pkg::RST_WIDE;
      actSteps <= dcrm_pkg::RST_WIDE;
      actRate <= dcrm_pkg::RST_WORD;
    end else if (applyEdge) begin
      actPll <= bufPll;
      actDac <= bufDac;
      actFreq <= bufFreq;
      actPhase <= bufPhase;
      actLimits <= bufLimits;
      actSteps <= bufSteps;
      actRate <= bufRate;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < PROFILE_COUNT; i++) begin
      if (rst) begin
        actProfile[i] <= dcrm_pkg::RST_PROFILE;
      end else if (applyEdge) begin
        actProfile[i] <= bufProfile[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the core, each from its own flip-flop.
  logic sweepOn;

  assign sweepOn = auxAccumEnable | modulusEnable;

  // The pulse leads the core outputs by one cycle: the active copies load
  // on the edge that raises it, and the outputs follow on the next edge.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      applyPulse <= 1'b0;
    end else begin
      applyPulse <= applyEdge;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pllDivOut <= 1'b0;
      pllMult <= '0;
      cmosClockMode <= 1'b0;
      crystalClockMode <= 1'b0;
      pllPowerDown <= 1'b0;
      lowReferenceRange <= 1'b0;
      pllRefHalf <= 1'b0;
      oscillatorBandSelect <= 1'b0;
      pllLogicReset <= 1'b1;
    end else begin
      pllDivOut <= actPll.divOut;
      pllMult <= actPll.mult;
      cmosClockMode <= actPll.cmosMode;
      crystalClockMode <= actPll.xtalMode;
      pllPowerDown <= actPll.powerDown;
      lowReferenceRange <= actPll.lowReferenceRange;
      pllRefHalf <= actPll.divIn;
      oscillatorBandSelect <= actPll.oscillatorBandSelect;
      pllLogicReset <= ~actPll.run;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fullScaleCurrent <= '0;
      frequencyStepWord <= '0;
      phaseShiftWord <= '0;
    end else begin
      fullScaleCurrent <= actDac[dcrm_pkg::FSC_W-1:0];
      frequencyStepWord <= actFreq;
      phaseShiftWord <= actPhase[dcrm_pkg::PHASE_W-1:0];
    end
  end

  // Sweep values read as zero while the sweep is off, so a stale setting
  // cannot leak into the accumulator while it is off.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sweepEffective <= 1'b0;
      sweepLimits <= '0;
      sweepSteps <= '0;
      fallRampRate <= '0;
      riseRampRate <= '0;
    end else begin
      sweepEffective <= sweepOn;
      sweepLimits <= sweepOn ? actLimits : '0;
      sweepSteps <= sweepOn ? actSteps : '0;
      fallRampRate <= sweepOn ?
        actRate[dcrm_pkg::RATE_HI_LSB +: dcrm_pkg::RATE_W] : '0;
      riseRampRate <= sweepOn ?
        actRate[dcrm_pkg::RATE_W-1:0] : '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      profileFreq <= '0;
      profilePhase <= '0;
    end else begin
      profileFreq <= actProfile[selSync].freq;
      profilePhase <= actProfile[selSync].phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back shows the buffered values, which is what the host wrote, except PLL bit 0, which shows the synchronised lock.
  logic [dcrm_pkg::DATA_W-1:0] next_rdData;
  logic [4:0] readOffset;

  assign readOffset = rdAddr - dcrm_pkg::ADDR_PROFILE_FIRST;

  always_comb begin
    next_rdData = '0;
    case (rdAddr)
      dcrm_pkg::ADDR_PLL_CTRL: begin
        next_rdData = {48'h0000_0000_0000, bufPll[15:1], lockSync};
      end
      dcrm_pkg::ADDR_DAC_CTRL: begin
        next_rdData = {32'h0000_0000, bufDac};
      end
      dcrm_pkg::ADDR_FREQ_STEP: begin
        next_rdData = {32'h0000_0000, bufFreq};
      end
      dcrm_pkg::ADDR_PHASE_SHIFT: begin
        next_rdData = {48'h0000_0000_0000, bufPhase};
      end
      dcrm_pkg::ADDR_SWEEP_LIMITS: begin
        next_rdData = bufLimits;
      end
      dcrm_pkg::ADDR_SWEEP_STEPS: begin
        next_rdData = bufSteps;
      end
      dcrm_pkg::ADDR_SWEEP_RATE: begin
        next_rdData = {32'h0000_0000, bufRate};
      end
      default: begin
        if (rdAddr >= dcrm_pkg::ADDR_PROFILE_FIRST &&
            rdAddr <= dcrm_pkg::ADDR_PROFILE_LAST) begin
          next_rdData = {16'h0000, bufProfile[readOffset[2:0]]};
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData <= '0;
      rdDone <= 1'b0;
    end else begin
      rdDone <= rdValid;
      if (rdValid) begin
        rdData <= next_rdData;
      end
    end
  end

endmodule : dcrm_register_bank

// ==== pkg/dcrm_pkg.sv ====
package dcrm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 5;
  localparam int DATA_W = 64;
  localparam int PROFILES = 8;
  localparam int PSEL_W = 3;

  localparam logic [4:0] ADDR_PLL_CTRL = 5'h01;
  localparam logic [4:0] ADDR_DAC_CTRL = 5'h02;
  localparam logic [4:0] ADDR_FREQ_STEP = 5'h03;
  localparam logic [4:0] ADDR_PHASE_SHIFT = 5'h04;
  localparam logic [4:0] ADDR_SWEEP_LIMITS = 5'h06;
  localparam logic [4:0] ADDR_SWEEP_STEPS = 5'h07;
  localparam logic [4:0] ADDR_SWEEP_RATE = 5'h08;
  localparam logic [4:0] ADDR_PROFILE_FIRST = 5'h09;
  localparam logic [4:0] ADDR_PROFILE_LAST = 5'h10;

  localparam int PLL_DIV_OUT_BIT = 15;
  localparam int PLL_MULT_LSB = 9;
  localparam int PLL_MULT_W = 6;
  localparam int PLL_CMOS_BIT = 7;
  localparam int PLL_XTAL_BIT = 6;
  localparam int PLL_PWRDN_BIT = 5;
  localparam int PLL_LORANGE_BIT = 4;
  localparam int PLL_DIV_IN_BIT = 3;
  localparam int PLL_BAND_BIT = 2;
  localparam int PLL_RUN_BIT = 1;
  localparam int PLL_LOCK_BIT = 0;

  localparam int FSC_W = 10;
  localparam int PHASE_W = 14;
  localparam int WORD_W = 32;
  localparam int RATE_W = 16;
  localparam int HI_LSB = 32;
  localparam int RATE_HI_LSB = 16;

  localparam logic [15:0] RST_PLL_CTRL = 16'h0000;
  localparam logic [31:0] RST_DAC_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_PHASE = 16'h0000;
  localparam logic [63:0] RST_WIDE = 64'h0000_0000_0000_0000;
  localparam logic [47:0] RST_PROFILE = 48'h0000_0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic divOut;
    logic [5:0] mult;
    logic keepDefault;
    logic cmosMode;
    logic xtalMode;
    logic powerDown;
    logic lowReferenceRange;
    logic divIn;
    logic oscillatorBandSelect;
    logic run;
    logic lockStatus;
  } dcrm_pll_t;

  typedef struct packed {
    logic [31:0] upper;
    logic [31:0] lower;
  } dcrm_pair_t;

  typedef struct packed {
    logic [1:0] open;
    logic [13:0] phase;
    logic [31:0] freq;
  } dcrm_profile_t;

endpackage : dcrm_pkg

// ==== sim/dcrm_host_model.sv ====
`timescale 1ns/1ps
module dcrm_host_model (
  input wire logic sys_clk,
  output logic wrValid,
  output logic [4:0] wrAddr,
  output logic [63:0] wrData,
  output logic rdValid,
  output logic [4:0] rdAddr,
  output logic applyPin,
  input wire logic [63:0] rdData,
  input wire logic rdDone
);
  initial begin
    wrValid = 1'b0;
    wrAddr = 5'h00;
    wrData = 64'h0;
    rdValid = 1'b0;
    rdAddr = 5'h00;
    applyPin = 1'b0;
  end

  task automatic write_reg(input logic [4:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    wrValid <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    @(posedge sys_clk);
    wrValid <= 1'b0;
    // Released data is inverted so a stale copy cannot look valid.
    wrData <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [4:0] a, output logic [63:0] d,
    output logic ok);
    ok = 1'b0;
    d = 64'h0;
    @(posedge sys_clk);
    rdValid <= 1'b1;
    rdAddr <= a;
    @(posedge sys_clk);
    rdValid <= 1'b0;
    // The answer is taken at the edge where the done pulse is seen.
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge sys_clk);
      ok = (rdDone === 1'b1);
      d = rdData;
    end
  endtask : read_reg

  // Apply follows each write burst within cycles, far inside 40 us.
  task automatic apply_regs();
    @(posedge sys_clk);
    applyPin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    applyPin <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : apply_regs
endmodule : dcrm_host_model

// ==== sim/dcrm_register_bank_asserts.sv ====
`timescale 1ns/1ps
module dcrm_register_bank_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rdValid,
  input wire logic [4:0] rdAddr,
  input wire logic [63:0] rdData,
  input wire logic rdDone,
  input wire logic applyPin,
  input wire logic auxAccumEnable,
  input wire logic modulusEnable,
  input wire logic applyPulse,
  input wire logic [5:0] pllMult,
  input wire logic pllPowerDown,
  input wire logic pllLogicReset,
  input wire logic [9:0] fullScaleCurrent,
  input wire logic [31:0] frequencyStepWord,
  input wire logic sweepEffective,
  input wire dcrm_pkg::dcrm_pair_t sweepLimits,
  input wire logic [15:0] riseRampRate
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rdValid |=> rdDone)
    else $error("read not answered");
  a_read_idle: assert property (!rdValid |=> !rdDone)
    else $error("read done without request");
  a_unmapped_zero: assert property (rdValid && (rdAddr == 5'h00 ||
    rdAddr == 5'h05 || rdAddr > 5'h10) |=> rdData == 64'h0)
    else $error("unmapped read not zero");
  a_apply_single: assert property (applyPulse |=> !applyPulse)
    else $error("apply pulse too long");
  a_apply_sync: assert property (!applyPin ##1 !applyPin ##1 applyPin
    |-> ##[2:4] applyPulse)
    else $error("apply strobe lost");
  a_hold_pll: assert property ($changed({pllMult, pllPowerDown,
    pllLogicReset}) |-> $past(applyPulse))
    else $error("pll field moved without apply");
  a_hold_word: assert property ($changed({fullScaleCurrent,
    frequencyStepWord}) |-> $past(applyPulse))
    else $error("word moved without apply");
  a_sweep_follow: assert property (!$past(rst) |->
    sweepEffective == $past(auxAccumEnable | modulusEnable))
    else $error("sweep enable not followed");
  a_sweep_zero: assert property (!sweepEffective |->
    sweepLimits == 64'h0 && riseRampRate == 16'h0)
    else $error("sweep value leaks while off");
  c_apply: cover property (applyPulse);
  c_read: cover property (rdDone);
  c_sweep: cover property ($rose(sweepEffective));
endmodule : dcrm_register_bank_asserts

bind dcrm_register_bank dcrm_register_bank_asserts i_chk (
  .sys_clk(sys_clk), .rst(rst), .rdValid(rdValid), .rdAddr(rdAddr),
  .rdData(rdData), .rdDone(rdDone), .applyPin(applyPin),
  .auxAccumEnable(auxAccumEnable), .modulusEnable(modulusEnable),
  .applyPulse(applyPulse), .pllMult(pllMult), .pllPowerDown(pllPowerDown),
  .pllLogicReset(pllLogicReset), .fullScaleCurrent(fullScaleCurrent),
  .frequencyStepWord(frequencyStepWord), .sweepEffective(sweepEffective),
  .sweepLimits(sweepLimits), .riseRampRate(riseRampRate));

// ==== sim/test_dcrm_register_bank.sv ====
`timescale 1ns/1ps
module test_dcrm_register_bank;
  logic sys_clk, rst, wrValid, rdValid, rdDone, applyPin, pllLockIn;
  logic auxAccumEnable, modulusEnable, applyPulse, pllDivOut, pllPowerDown;
  logic cmosClockMode, crystalClockMode, lowReferenceRange, pllRefHalf;
  logic oscillatorBandSelect, pllLogicReset, sweepEffective;
  logic [4:0] wrAddr, rdAddr;
  logic [63:0] wrData, rdData, d, shadow [0:17];
  logic [2:0] profileSelectPin;
  logic [5:0] pllMult;
  logic [9:0] fullScaleCurrent;
  logic [31:0] frequencyStepWord, profileFreq, seed, lastFtw;
  logic [13:0] phaseShiftWord, profilePhase;
  logic [15:0] fallRampRate, riseRampRate;
  dcrm_pkg::dcrm_pair_t sweepLimits, sweepSteps;
  int fail_count = 0;
  int n_tests = 0;

  dcrm_register_bank i_dut (
    .sys_clk(sys_clk), .rst(rst), .wrValid(wrValid), .wrAddr(wrAddr),
    .wrData(wrData), .rdValid(rdValid), .rdAddr(rdAddr), .rdData(rdData),
    .rdDone(rdDone), .applyPin(applyPin),
    .profileSelectPin(profileSelectPin), .pllLockIn(pllLockIn),
    .auxAccumEnable(auxAccumEnable), .modulusEnable(modulusEnable),
    .applyPulse(applyPulse), .pllDivOut(pllDivOut), .pllMult(pllMult),
    .cmosClockMode(cmosClockMode), .crystalClockMode(crystalClockMode),
    .pllPowerDown(pllPowerDown), .lowReferenceRange(lowReferenceRange),
    .pllRefHalf(pllRefHalf), .oscillatorBandSelect(oscillatorBandSelect),
    .pllLogicReset(pllLogicReset), .fullScaleCurrent(fullScaleCurrent),
    .frequencyStepWord(frequencyStepWord), .phaseShiftWord(phaseShiftWord),
    .sweepEffective(sweepEffective), .sweepLimits(sweepLimits),
    .sweepSteps(sweepSteps), .fallRampRate(fallRampRate),
    .riseRampRate(riseRampRate), .profileFreq(profileFreq),
    .profilePhase(profilePhase));

  dcrm_host_model i_host (
    .sys_clk(sys_clk), .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData),
    .rdValid(rdValid), .rdAddr(rdAddr), .applyPin(applyPin),
    .rdData(rdData), .rdDone(rdDone));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Open bits stay at default; the reference is assumed above 5 MHz.
  function automatic logic [63:0] legal(input int a, input logic [63:0] v);
    case (a)
      1: return v & 64'hFEEF;
      2: return v & 64'h3FF;
      3, 8: return v & 64'hFFFF_FFFF;
      4: return v & 64'h3FFF;
      6, 7: return v;
      default: return v & 64'h3FFF_FFFF_FFFF;
    endcase
  endfunction : legal

  function automatic logic [63:0] expv(input int a);
    if (a == 0 || a == 5 || a > 16) return 64'h0;
    if (a == 1) return (shadow[1] & 64'hFFFE) | 64'(pllLockIn);
    return shadow[a];
  endfunction : expv

  task automatic check(input string n, input logic [63:0] e,
    input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : check

  task automatic rd_check(input int a);
    logic [63:0] v;
    logic ok;
    i_host.read_reg(5'(a), v, ok);
    if (!ok) begin
      fail_count++;
      print_verdict();
    end else begin
      check("read", expv(a), v);
    end
  endtask : rd_check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'b1;
    pllLockIn = 1'b0;
    auxAccumEnable = 1'b0;
    modulusEnable = 1'b0;
    profileSelectPin = 3'h0;
    seed = 32'h7C49;
    lastFtw = 32'h0000_0000;
    for (int a = 0; a < 18; a++) shadow[a] = 64'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    check("plrst", 64'h1, 64'(pllLogicReset));
    for (int a = 0; a < 18; a++) rd_check(a);
    pllLockIn <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      for (int a = 0; a < 18; a++) begin
        d = (r == 0) ? '1 : {seed, lfsr(seed)};
        seed = lfsr(lfsr(seed));
        if (a != 0 && a != 5 && a < 17) shadow[a] = legal(a, d);
        i_host.write_reg(5'(a), legal(a, d));
      end
      for (int a = 0; a < 18; a++) rd_check(a);
      check("early", 64'(lastFtw), 64'(frequencyStepWord));
      auxAccumEnable <= r[0];
      modulusEnable <= r[1];
      i_host.apply_regs();
      check("pll", 64'({shadow[1][15:9], shadow[1][7:1]}),
        64'({pllDivOut, pllMult, cmosClockMode, crystalClockMode,
        pllPowerDown, lowReferenceRange, pllRefHalf, oscillatorBandSelect,
        ~pllLogicReset}));
      check("fsc", shadow[2], 64'(fullScaleCurrent));
      check("ftw", shadow[3], 64'(frequencyStepWord));
      lastFtw = shadow[3][31:0];
      check("pow", shadow[4], 64'(phaseShiftWord));
      check("lim", r ? shadow[6] : 64'h0, sweepLimits);
      check("stp", r ? shadow[7] : 64'h0, sweepSteps);
      check("rate", r ? shadow[8] : 64'h0,
        64'({fallRampRate, riseRampRate}));
      for (int p = 0; p < 8; p++) begin
        profileSelectPin <= 3'(p);
        repeat (6) @(posedge sys_clk);
        check("prof", shadow[9 + p],
          64'({profilePhase, profileFreq}));
      end
    end
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    check("ftw0", 64'h0, 64'(frequencyStepWord));
    for (int a = 0; a < 18; a++) shadow[a] = 64'h0;
    for (int a = 0; a < 18; a++) rd_check(a);
    print_verdict();
  end
endmodule : test_dcrm_register_bank
